/* hdl/data_watchpoint_unit.sv */
// Purpose: Data watchpoint unit: watch register, watch control fields and match logic.
// Assumes: Requests arrive from load/store and register-access logic on the core clock.
// Notes: Exception outputs are registered and appear one cycle after the access.
`timescale 1ns/10ps
module data_watchpoint_unit
  import watch_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register access port
  input watch_pkg::reg_req_t reg_req,
  output logic [63:0] reg_rdata_q,
  output logic reg_ack_q,
  output logic reg_priv_fault_q,
  // Load/store pipeline
  input watch_pkg::access_req_t acc,
  output watch_pkg::watch_hit_t basic_hit_q,
  output watch_pkg::watch_hit_t ext_hit_q,
  output logic data_access_exc_q
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [60:0] watched_address_field_q;
  logic [7:0] watch_byte_mask_q;
  logic phys_read_watch_en_q;
  logic phys_write_watch_en_q;
  logic virt_read_watch_en_q;
  logic virt_write_watch_en_q;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // A register answers only when both its space and its offset agree.
  function automatic logic reg_select(input logic [7:0] asi, input logic [63:0] va,
                                      input logic [7:0] want_asi,
                                      input logic [63:0] want_va);
    return (asi == want_asi) && (va == want_va);
  endfunction

  // An atomic access moves both ways, so either armed direction is enough.
  function automatic logic dir_armed(input logic is_read, input logic is_write,
                                     input logic read_en, input logic write_en);
    return (is_read && read_en) || (is_write && write_en);
  endfunction

  // Only translating and bypass spaces are watched; the rest are never compared.
  function automatic logic class_watched(input asi_class_t cls);
    return (cls == asi_translating) || (cls == asi_bypass);
  endfunction

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic sel_watch;
  logic sel_ctrl;
  logic priv_ok;
  logic wr_watch;
  logic wr_ctrl;
  logic sel_any;
  logic user_hit;
  logic [60:0] wdata_addr;
  logic [7:0] wdata_mask;
  logic [63:0] ctrl_view;
  logic [63:0] rdata_d;

  // Both registers are supervisor only; a user access is refused and flagged.
  assign sel_watch = reg_select(reg_req.asi, reg_req.va, WATCH_ASI, WATCH_VA);
  assign sel_ctrl = reg_select(reg_req.asi, reg_req.va, CTRL_ASI, CTRL_VA);
  assign sel_any = sel_watch || sel_ctrl;
  assign priv_ok = reg_req.valid && reg_req.priv;
  assign wr_watch = priv_ok && reg_req.write && sel_watch;
  assign wr_ctrl = priv_ok && reg_req.write && sel_ctrl;
  // A user request to a mapped register is refused: nothing is written and it reads zero.
  assign user_hit = reg_req.valid && !reg_req.priv && sel_any;

  // Write fields are cut out once; reserved write bits are simply dropped.
  assign wdata_addr = reg_req.wdata[WATCH_ADDR_HI:WATCH_ADDR_LO];
  assign wdata_mask = reg_req.wdata[MASK_HI:MASK_LO];

  // Only the watch fields of the control register live here; other bits read zero.
  always_comb begin
    ctrl_view = 64'h0;
    ctrl_view[MASK_HI:MASK_LO] = watch_byte_mask_q;
    ctrl_view[PR_BIT] = phys_read_watch_en_q;
    ctrl_view[PW_BIT] = phys_write_watch_en_q;
    ctrl_view[VR_BIT] = virt_read_watch_en_q;
    ctrl_view[VW_BIT] = virt_write_watch_en_q;
  end

  // Low three bits of the watch register are reserved and read as zero.
  assign rdata_d = !priv_ok || reg_req.write ? 64'h0 :
                   sel_watch ? {watched_address_field_q, 3'h0} :
                   sel_ctrl ? ctrl_view : 64'h0;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // The watch address has no defined reset value; zero keeps it known until programmed.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      watched_address_field_q <= WATCH_ADDR_RESET;
    end else if (wr_watch) begin
      watched_address_field_q <= wdata_addr;
    end
  end

  // Control fields share one write strobe.
  // Reserved control bits are not stored, so they always read back as zero.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      watch_byte_mask_q <= MASK_RESET;
      phys_read_watch_en_q <= EN_RESET;
      phys_write_watch_en_q <= EN_RESET;
      virt_read_watch_en_q <= EN_RESET;
      virt_write_watch_en_q <= EN_RESET;
    end else if (wr_ctrl) begin
      watch_byte_mask_q <= wdata_mask;
      phys_read_watch_en_q <= reg_req.wdata[PR_BIT];
      phys_write_watch_en_q <= reg_req.wdata[PW_BIT];
      virt_read_watch_en_q <= reg_req.wdata[VR_BIT];
      virt_write_watch_en_q <= reg_req.wdata[VW_BIT];
    end
  end

  // Answer every register request one cycle later.
  // Unmapped requests are acknowledged too, so software never waits on them.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata_q <= 64'h0;
      reg_ack_q <= 1'b0;
      reg_priv_fault_q <= 1'b0;
    end else begin
      reg_rdata_q <= rdata_d;
      reg_ack_q <= reg_req.valid;
      reg_priv_fault_q <= user_hit;
    end
  end

  // ----------------------------------------------------------------
  // Access qualification
  // ----------------------------------------------------------------
  logic space_watched;
  logic virt_dir_en;
  logic phys_dir_en;
  logic [1:0] op_live;
  logic [1:0] raw_virt;
  logic [1:0] raw_phys;
  logic space_unimpl;
  logic [1:0] virt_hit_d;
  logic [1:0] phys_hit_d;
  watch_hit_t [1:0] hit_d;
  mem_op_t [1:0] ops;

  // Nontranslating and unimplemented spaces are never compared.
  assign space_watched = acc.valid && class_watched(acc.asi_class);
  // An unimplemented space is refused outright and never reaches the comparators.
  assign space_unimpl = acc.valid && (acc.asi_class == asi_unimplemented);
  // Either direction may arm the match; an atomic sets both.
  assign virt_dir_en = dir_armed(acc.is_read, acc.is_write, virt_read_watch_en_q,
                                 virt_write_watch_en_q);
  assign phys_dir_en = dir_armed(acc.is_read, acc.is_write, phys_read_watch_en_q,
                                 phys_write_watch_en_q);
  // Both halves go through identical comparators so they are judged alike.
  assign ops[0] = acc.basic;
  assign ops[1] = acc.ext;
  // The extended half only counts for a SIMD access.
  assign op_live[0] = space_watched;
  assign op_live[1] = space_watched && acc.simd;

  // ----------------------------------------------------------------
  // Per-operation comparison
  // ----------------------------------------------------------------
  // The extended half of a SIMD access is judged on its own address and length.
  for (genvar g = 0; g < 2; g++) begin : g_op
    watch_compare u_cmp (
      .op(ops[g]),
      .watched(watched_address_field_q),
      .mask(watch_byte_mask_q),
      .virt_hit(raw_virt[g]),
      .phys_hit(raw_phys[g])
    );
    assign virt_hit_d[g] = op_live[g] && virt_dir_en && raw_virt[g];
    // The virtual exception takes precedence when both interpretations hit.
    assign phys_hit_d[g] = op_live[g] && phys_dir_en && raw_phys[g] &&
                           !virt_hit_d[g];
    assign hit_d[g].virt_watch = virt_hit_d[g];
    assign hit_d[g].phys_watch = phys_hit_d[g];
  end

  // ----------------------------------------------------------------
  // Registered exception outputs
  // ----------------------------------------------------------------
  // Each exception is a pulse that stands for the one cycle after its access.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      basic_hit_q <= '0;
      ext_hit_q <= '0;
      data_access_exc_q <= 1'b0;
    end else begin
      basic_hit_q <= hit_d[0];
      ext_hit_q <= hit_d[1];
      data_access_exc_q <= space_unimpl;
    end
  end

endmodule // data_watchpoint_unit

/* hdl/watch_compare.sv */
// Purpose: Address and byte-lane comparison of one memory operation against the watch.
// Assumes: Length is 1 to 8 bytes and the access stays within one doubleword.
// Notes: Purely combinational; enables and priority are applied by the caller.
`timescale 1ns/10ps
module watch_compare
  import watch_pkg::*;
(
  // Operation under test
  input watch_pkg::mem_op_t op,
  // Programmed watch
  input wire logic [60:0] watched,
  input wire logic [7:0] mask,
  // Raw hits
  output logic virt_hit,
  output logic phys_hit
);

  // ----------------------------------------------------------------
  // Byte lanes touched within the doubleword
  // ----------------------------------------------------------------
  function automatic logic [7:0] byte_lanes(input logic [2:0] off, input logic [3:0] len);
    logic [7:0] lanes;
    lanes = 8'h00;
    for (int i = 0; i < 8; i++) begin
      lanes[i] = (4'(i) >= {1'b0, off}) && (4'(i) < ({1'b0, off} + len));
    end
    return lanes;
  endfunction

  logic [7:0] lanes_hit;
  logic virt_addr_eq;
  logic phys_addr_eq;

  // A lane counts only if the access touches it and the mask selects it.
  assign lanes_hit = byte_lanes(op.addr_virt[2:0], op.len) & mask;
  assign virt_addr_eq = (op.addr_virt[WATCH_ADDR_HI:WATCH_ADDR_LO] == watched);
  // Upper watched bits do not exist in the physical space, so they are left out.
  assign phys_addr_eq = (op.addr_phys[PHYS_ADDR_HI:WATCH_ADDR_LO] ==
                         watched[PHYS_ADDR_HI-WATCH_ADDR_LO:0]);
  assign virt_hit = virt_addr_eq && (|lanes_hit);
  assign phys_hit = phys_addr_eq && (|lanes_hit);

endmodule // watch_compare

/* hdl/watch_pkg.sv */
// Purpose: Shared constants and types for the data watchpoint unit.
// Assumes: One core clock; register and pipeline requests come from logic on that clock.
// Notes: Register locations are alternate-space identifier plus virtual offset pairs.
package watch_pkg;

  // ----------------------------------------------------------------
  // Register locations
  // ----------------------------------------------------------------
  localparam logic [7:0] WATCH_ASI = 8'h58;
  localparam logic [63:0] WATCH_VA = 64'h0000000000000038;
  localparam logic [7:0] CTRL_ASI = 8'h45;
  localparam logic [63:0] CTRL_VA = 64'h0000000000000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WATCH_ADDR_LO = 3;
  localparam int WATCH_ADDR_HI = 63;
  localparam int PHYS_ADDR_HI = 40;
  localparam int MASK_LO = 25;
  localparam int MASK_HI = 32;
  localparam int PR_BIT = 24;
  localparam int PW_BIT = 23;
  localparam int VR_BIT = 22;
  localparam int VW_BIT = 21;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [60:0] WATCH_ADDR_RESET = 61'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic EN_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    asi_translating,
    asi_bypass,
    asi_nontranslating,
    asi_unimplemented
  } asi_class_t;

  typedef struct packed {
    logic [63:0] addr_virt;
    logic [63:0] addr_phys;
    logic [3:0] len;
  } mem_op_t;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic is_write;
    asi_class_t asi_class;
    logic simd;
    mem_op_t basic;
    mem_op_t ext;
  } access_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic [7:0] asi;
    logic [63:0] va;
    logic [63:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic virt_watch;
    logic phys_watch;
  } watch_hit_t;

endpackage

/* verification/lsu_model.sv */
// Purpose: Load/store pipeline model feeding the unit.
// Assumes: The bench calls issue between clock edges.
// Notes: A released bus shows inverted values, never the old access.
`timescale 1ns/10ps
module lsu_model
  import watch_pkg::*;
(
  // Clock
  input wire logic clock,
  // Access to the unit
  output watch_pkg::access_req_t acc
);
  initial acc = '0;
  // One-cycle access; scrambling afterwards exposes stale sampling.
  task automatic issue(input access_req_t r);
    @(posedge clock);
    acc <= r;
    @(posedge clock);
    acc <= access_req_t'({1'b0, ~r[$bits(r)-2:0]});
    #1;
  endtask
endmodule // lsu_model

/* verification/tb.sv */
// Purpose: Self-checking bench for the data watchpoint unit.
// Assumes: Outputs answer one cycle after each request.
// Notes: Expected values come from the enables, mask and lanes.
`timescale 1ns/10ps
module tb;
  import watch_pkg::*;
  localparam logic [63:0] W = 64'h00AB_0000_1234_5678;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  reg_req_t rq = '0;
  access_req_t acc, r;
  logic [63:0] rdata, rd;
  logic ack, fault, exc, fl;
  watch_hit_t bh, eh;
  int failures = 0;
  int total_checks = 0;
  data_watchpoint_unit i_data_watchpoint_unit (.clock(clock), .resetn(resetn),
    .reg_req(rq), .reg_rdata_q(rdata), .reg_ack_q(ack), .reg_priv_fault_q(fault),
    .acc(acc), .basic_hit_q(bh), .ext_hit_q(eh), .data_access_exc_q(exc));
  lsu_model i_lsu_model (.clock(clock), .acc(acc));
  // Clock at 200 MHz.
  initial forever #2.5 clock = ~clock;
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Register cycle; fields are scrambled once valid drops.
  task automatic reg_op(input logic w, p, input logic [7:0] a, input logic [63:0] d);
    @(posedge clock);
    rq <= '{1'b1, w, p, a, (a == 8'h59) ? WATCH_VA : ((a == WATCH_ASI) ? WATCH_VA : CTRL_VA), d};
    @(posedge clock);
    rq <= '{1'b0, ~w, ~p, ~a, 64'h5A, ~d};
    #1;
    check({63'h0, ack}, 64'h1);
    rd = rdata;
    fl = fault;
  endtask
  task automatic set_ctl(input logic [7:0] m, input logic [3:0] e);
    reg_op(1'b1, 1'b1, CTRL_ASI, {31'h0, m, e, 21'h0});
  endtask
  task automatic base();
    r = '0;
    r.valid = 1'b1;
    r.is_read = 1'b1;
    r.basic = '{W, W, 4'h8};
    r.ext = r.basic;
  endtask
  task automatic acc_chk(input logic [4:0] ex);
    i_lsu_model.issue(r);
    check({59'h0, bh, eh, exc}, {59'h0, ex});
  endtask
  task automatic t_regs();
    reg_op(1'b0, 1'b1, CTRL_ASI, 64'h0);
    check(rd, 64'h0);
    reg_op(1'b1, 1'b1, WATCH_ASI, '1);
    reg_op(1'b1, 1'b0, WATCH_ASI, W);
    check({63'h0, fl}, 64'h1);
    reg_op(1'b0, 1'b1, WATCH_ASI, 64'h0);
    check(rd, 64'hFFFF_FFFF_FFFF_FFF8);
    reg_op(1'b1, 1'b1, CTRL_ASI, '1);
    reg_op(1'b0, 1'b1, CTRL_ASI, 64'h0);
    check(rd, 64'h0000_0001_FFE0_0000);
    reg_op(1'b0, 1'b1, 8'h59, 64'h0);
    check(rd | {63'h0, fl}, 64'h0);
    reg_op(1'b1, 1'b1, WATCH_ASI, W);
  endtask
  // Every enable set against every direction, virtual and physical both matching.
  task automatic t_dir();
    logic v, p;
    for (int e = 0; e < 16; e++) begin
      set_ctl(8'hFF, e[3:0]);
      for (int d = 0; d < 4; d++) begin
        base();
        {r.is_write, r.is_read} = d[1:0];
        v = (d[0] & e[1]) | (d[1] & e[0]);
        p = ((d[0] & e[3]) | (d[1] & e[2])) & !v;
        acc_chk({v, p, 3'h0});
      end
    end
  endtask
  // Table entries hold offset in the high nibble and length in the low one.
  task automatic t_lanes();
    logic [7:0] tbl [5] = '{8'h04, 8'h05, 8'h41, 8'h53, 8'h18};
    logic [7:0] lm;
    set_ctl(8'h10, 4'h2);
    foreach (tbl[i]) begin
      base();
      r.basic.addr_virt[2:0] = tbl[i][6:4];
      r.basic.len = tbl[i][3:0];
      lm = 8'((16'h00FF >> (8 - tbl[i][3:0])) << tbl[i][6:4]);
      acc_chk({|(lm & 8'h10), 4'h0});
    end
    r.basic.addr_virt = W + 64'h8;
    acc_chk(5'h0);
    set_ctl(8'h00, 4'hF);
    base();
    acc_chk(5'h0);
  endtask
  // Physical upper bits ignored, bit 40 still compared; then classes and simd.
  task automatic t_misc();
    set_ctl(8'hFF, 4'h8);
    base();
    r.basic = '{~W, {23'h0, W[40:0]}, 4'h8};
    acc_chk(5'h08);
    r.basic.addr_phys[40] = 1'b1;
    acc_chk(5'h00);
    set_ctl(8'hFF, 4'hA);
    for (int c = 0; c < 4; c++) begin
      base();
      r.asi_class = asi_class_t'(c);
      acc_chk({c < 2, 3'h0, c == 3});
    end
    base();
    r.simd = 1'b1;
    r.basic.addr_virt = W + 64'h8;
    r.basic.addr_phys = W + 64'h8;
    acc_chk(5'h04);
    r.ext.addr_virt = W + 64'h10;
    acc_chk(5'h02);
    r.simd = 1'b0;
    acc_chk(5'h00);
  endtask
  // Main sequence after a 12-cycle reset.
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_dir();
    t_lanes();
    t_misc();
    finish_test();
  end
  // Watchdog well beyond the expected run of a few hundred cycles.
  initial begin
    #20000;
    failures++;
    finish_test();
  end
endmodule // tb

/* verification/watch_props.sv */
// Purpose: Port assertions for the data watchpoint unit.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the unit.
`timescale 1ns/10ps
module watch_props
  import watch_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input watch_pkg::reg_req_t reg_req,
  input wire logic [63:0] reg_rdata_q,
  input wire logic reg_ack_q,
  input wire logic reg_priv_fault_q,
  // Pipeline port
  input watch_pkg::access_req_t acc,
  input watch_pkg::watch_hit_t basic_hit_q,
  input watch_pkg::watch_hit_t ext_hit_q,
  input wire logic data_access_exc_q
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Upper class bit set means nontranslating or unimplemented space.
  sequence unimp_s;
    acc.valid && acc.asi_class == asi_unimplemented;
  endsequence
  sequence skip_s;
    acc.valid && acc.asi_class[1];
  endsequence
  ack_pulse_a: assert property (reg_req.valid |=> reg_ack_q)
    else $error("register ack missing");
  user_refuse_a:
    assert property (reg_req.valid && !reg_req.priv && reg_req.asi == WATCH_ASI
      && reg_req.va == WATCH_VA |=> reg_priv_fault_q && reg_rdata_q == 64'h0)
    else $error("user access not refused");
  exc_unimp_a: assert property (unimp_s |=> data_access_exc_q)
    else $error("data access exception missing");
  exc_cause_a:
    assert property (data_access_exc_q |-> $past(acc.valid && acc.asi_class[1:0] == 2'h3))
    else $error("stray data access exception");
  no_compare_a:
    assert property (skip_s |=> basic_hit_q == 2'h0 && ext_hit_q == 2'h0)
    else $error("uncompared space raised a hit");
  virt_first_a: assert property (!(&basic_hit_q) && !(&ext_hit_q))
    else $error("both hit kinds at once");
  ext_simd_a: assert property (acc.valid && !acc.simd |=> ext_hit_q == 2'h0)
    else $error("extended hit without simd");
  no_dir_a:
    assert property (acc.valid && !acc.is_read && !acc.is_write |=> basic_hit_q == 2'h0)
    else $error("hit without direction");
endmodule // watch_props

bind data_watchpoint_unit watch_props i_watch_props (.clock(clock), .resetn(resetn),
  .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
  .reg_priv_fault_q(reg_priv_fault_q), .acc(acc), .basic_hit_q(basic_hit_q),
  .ext_hit_q(ext_hit_q), .data_access_exc_q(data_access_exc_q));
